//--- inc/crthp_pkg.sv
// Constants shared by the display controller host bus port.
package crthp_pkg;
   localparam int DATA_W = 8;
   localparam int INDEX_W = 5;
   localparam int STATUS_W = 2;
   localparam int SYNC_STAGES = 3;
   localparam logic [INDEX_W-1:0] INDEX_RST = 5'h00;
   localparam logic [DATA_W-1:0] REG_RST = 8'h00;
   localparam int NUM_REGS = 32;
endpackage : crthp_pkg

//--- design/crthp_port.sv
// Host bus port of the display timing controller: index pointer, status and register file.
// Operation
// - Every write is framed by a strobe pulse; reads follow the select and direction levels.
// - Strobe may idle arbitrarily long between pulses.
// - Direction high reads, low writes.
// - Respond only while chip select is low.
// - Select low: write index, read status.
// - Select high: access register named by index.
// - Data lines driven only during selected reads.
// - Index pointer is five bits, registers 0-31.
// - Status register reports two condition bits.
`timescale 1ns/1ps
module crthp_port #(
   parameter int NUM_REGS = crthp_pkg::NUM_REGS
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic xfer_strobe,
   input wire logic read_not_write,
   input wire logic chip_select_n,
   input wire logic register_select_line,
   input wire logic [crthp_pkg::DATA_W-1:0] host_data_lines_in,
   output logic [crthp_pkg::DATA_W-1:0] host_data_lines_out,
   output logic host_data_lines_oe,
   input wire logic [crthp_pkg::STATUS_W-1:0] ctrl_status,
   output logic [crthp_pkg::INDEX_W-1:0] index_ptr,
   output logic [NUM_REGS*crthp_pkg::DATA_W-1:0] reg_file_flat,
   output logic reg_wr_pulse,
   output logic [crthp_pkg::INDEX_W-1:0] reg_wr_index
);
   localparam int DW = crthp_pkg::DATA_W;
   localparam int IW = crthp_pkg::INDEX_W;
   localparam int NS = crthp_pkg::SYNC_STAGES;

   // The index pointer cannot name more registers than its width allows.
   if (NUM_REGS < 1 || NUM_REGS > (1 << IW)) begin : g_num_regs_check
      $error("NUM_REGS out of range");
   end

   // A filtered level may move only when the two later stages hold the same value.
   function automatic logic agree2(input logic [1:0] pair);
      return pair[1] == pair[0];
   endfunction : agree2

   // Pin inputs pass three stages; a change counts when stages two and three agree.
   logic [NS-1:0] stb_sync_r;
   logic [NS-1:0] rw_sync_r;
   logic [NS-1:0] cs_sync_r;
   logic [NS-1:0] rs_sync_r;
   logic [DW-1:0] d_s1_r;
   logic [DW-1:0] d_s2_r;
   logic [DW-1:0] d_s3_r;
   logic stb_q_r;
   logic rw_q_r;
   logic cs_n_q_r;
   logic rs_q_r;
   logic [DW-1:0] d_q_r;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         stb_sync_r <= '0;
         rw_sync_r <= '1;
         cs_sync_r <= '1;
         rs_sync_r <= '0;
         d_s1_r <= '0;
         d_s2_r <= '0;
         d_s3_r <= '0;
      end else begin
         stb_sync_r <= {stb_sync_r[NS-2:0], xfer_strobe};
         rw_sync_r <= {rw_sync_r[NS-2:0], read_not_write};
         cs_sync_r <= {cs_sync_r[NS-2:0], chip_select_n};
         rs_sync_r <= {rs_sync_r[NS-2:0], register_select_line};
         d_s1_r <= host_data_lines_in;
         d_s2_r <= d_s1_r;
         d_s3_r <= d_s2_r;
      end
   end

   wire stb_agree = agree2(stb_sync_r[2:1]);
   wire rw_agree = agree2(rw_sync_r[2:1]);
   wire cs_agree = agree2(cs_sync_r[2:1]);
   wire rs_agree = agree2(rs_sync_r[2:1]);
   wire d_agree = (d_s2_r == d_s3_r);
   // A level that is still settling keeps its old filtered value, so no glitch reaches decode.

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         stb_q_r <= 1'b0;
         rw_q_r <= 1'b1;
         cs_n_q_r <= 1'b1;
         rs_q_r <= 1'b0;
         d_q_r <= '0;
      end else begin
         if (stb_agree) stb_q_r <= stb_sync_r[2];
         if (rw_agree) rw_q_r <= rw_sync_r[2];
         if (cs_agree) cs_n_q_r <= cs_sync_r[2];
         if (rs_agree) rs_q_r <= rs_sync_r[2];
         if (d_agree) d_q_r <= d_s3_r;
      end
   end

   // The strobe is edge detected, so no free-running strobe is assumed.
   wire stb_fall = stb_q_r && stb_agree && !stb_sync_r[2];
   wire selected = !cs_n_q_r;
   wire wr_cycle = stb_fall && selected && !rw_q_r;
   wire wr_index = wr_cycle && !rs_q_r;
   wire wr_reg = wr_cycle && rs_q_r;

   logic [IW-1:0] index_r;
   logic [DW-1:0] regs_r [NUM_REGS];
   logic wr_pulse_r;
   logic [IW-1:0] wr_idx_r;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         index_r <= crthp_pkg::INDEX_RST;
      end else if (wr_index) begin
         // Only the low five data bits reach the pointer; the upper bits are ignored.
         index_r <= d_q_r[IW-1:0];
      end
   end

   // Each register is plain storage; what the bits mean is left to the controller core.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
         always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
               regs_r[gi] <= crthp_pkg::REG_RST;
            end else if (wr_reg && index_r == IW'(gi)) begin
               regs_r[gi] <= d_q_r;
            end
         end
         assign reg_file_flat[gi*DW +: DW] = regs_r[gi];
      end
   endgenerate

   // The core sees a register write as a one-cycle pulse with the index it went to.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wr_pulse_r <= 1'b0;
         wr_idx_r <= '0;
      end else begin
         wr_pulse_r <= wr_reg;
         wr_idx_r <= index_r;
      end
   end

   // Reads: data is presented while selected and reading; unmapped indices read zero.
   wire rd_active = selected && rw_q_r;
   wire idx_mapped = (int'(index_r) < NUM_REGS);
   wire [DW-1:0] status_word = {{(DW-crthp_pkg::STATUS_W){1'b0}}, ctrl_status};
   wire [DW-1:0] reg_word = idx_mapped ? regs_r[index_r] : '0;
   wire [DW-1:0] rd_word = rs_q_r ? reg_word : status_word;

   logic [DW-1:0] rd_data_r;
   logic rd_oe_r;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rd_data_r <= '0;
         rd_oe_r <= 1'b0;
      end else begin
         rd_data_r <= rd_word;
         rd_oe_r <= rd_active;
      end
   end

   assign host_data_lines_out = rd_data_r;
   assign host_data_lines_oe = rd_oe_r;
   assign index_ptr = index_r;
   assign reg_wr_pulse = wr_pulse_r;
   assign reg_wr_index = wr_idx_r;

   // Checks look at the pointer, the pulse and the pins as well as at the filtered levels and decode terms.
   sequence s_wr_idx;
      wr_index ##1 1'b1;
   endsequence

   sequence s_stb_fell;
      $past(stb_q_r) && !stb_q_r;
   endsequence

   AST_INDEX_LOAD: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_wr_idx |-> index_r == $past(d_q_r[IW-1:0]))
      else $error("index not loaded on write");
   AST_INDEX_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !wr_index |=> $stable(index_r))
      else $error("index changed without write");
   AST_NO_WRITE_UNSELECTED: assert property (@(posedge clk_sys) disable iff (!arst_n)
      cs_n_q_r |=> $stable(index_r) && !reg_wr_pulse)
      else $error("write while unselected");
   AST_OE_OFF_UNSELECTED: assert property (@(posedge clk_sys) disable iff (!arst_n)
      cs_n_q_r |=> !host_data_lines_oe)
      else $error("data driven while unselected");
   AST_OE_ONLY_READ: assert property (@(posedge clk_sys) disable iff (!arst_n)
      host_data_lines_oe |-> $past(!cs_n_q_r && rw_q_r))
      else $error("data driven outside read");
   AST_OE_ON_READ: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (!cs_n_q_r && rw_q_r) |=> host_data_lines_oe)
      else $error("read not driven");
   AST_STATUS_READ: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (!rs_q_r) |=> host_data_lines_out == {6'h00, $past(ctrl_status)})
      else $error("status data wrong");
   AST_REG_WRITE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      wr_reg && idx_mapped |=> regs_r[$past(index_r)] == $past(d_q_r) && reg_wr_pulse)
      else $error("register write lost");
   AST_WR_INDEX: assert property (@(posedge clk_sys) disable iff (!arst_n)
      reg_wr_pulse |-> reg_wr_index == $past(index_r))
      else $error("write pulse index wrong");
   AST_WRITE_NEEDS_STROBE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      reg_wr_pulse |-> s_stb_fell)
      else $error("write without strobe");
   AST_WR_PULSE_ONE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      reg_wr_pulse |=> !reg_wr_pulse)
      else $error("write pulse longer than one cycle");
   AST_WRITE_DIR: assert property (@(posedge clk_sys) disable iff (!arst_n)
      rd_active |=> $stable(index_r) && !reg_wr_pulse)
      else $error("write with read direction");
   AST_FALL_EDGE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      $changed(index_r) |-> s_stb_fell)
      else $error("write not on falling strobe");
endmodule : crthp_port

//--- verif/crthp_host.sv
// Host processor model that drives the port's bus pins.
`timescale 1ns/1ps
module crthp_host (
   input wire logic clk_sys,
   output logic xfer_strobe,
   output logic read_not_write,
   output logic chip_select_n,
   output logic register_select_line,
   output logic [7:0] host_drv,
   input wire logic [7:0] bus
);
   initial begin
      xfer_strobe = 1'b0;
      read_not_write = 1'b1;
      chip_select_n = 1'b1;
      register_select_line = 1'b0;
      host_drv = 8'h00;
   end
   // A released bus shows the inverse of the last byte, so stale data cannot pass a read.
   task automatic cyc(input logic c, input logic r, input logic s, input logic [7:0] d,
         output logic [7:0] q);
      @(posedge clk_sys);
      chip_select_n <= c;
      read_not_write <= r;
      register_select_line <= s;
      host_drv <= r ? ~d : d;
      repeat (4) @(posedge clk_sys);
      xfer_strobe <= 1'b1;
      repeat (6) @(posedge clk_sys);
      q = bus;
      xfer_strobe <= 1'b0;
      repeat (6) @(posedge clk_sys);
      chip_select_n <= 1'b1;
      read_not_write <= 1'b1;
      host_drv <= ~d;
      repeat (6) @(posedge clk_sys);
   endtask : cyc
   // Pins set up for a write that is never strobed; nothing may be written.
   task automatic nostb(input logic [7:0] d);
      @(posedge clk_sys);
      chip_select_n <= 1'b0;
      read_not_write <= 1'b0;
      register_select_line <= 1'b0;
      host_drv <= d;
      repeat (16) @(posedge clk_sys);
      chip_select_n <= 1'b1;
      read_not_write <= 1'b1;
      host_drv <= ~d;
      repeat (6) @(posedge clk_sys);
   endtask : nostb
endmodule : crthp_host

//--- verif/tb.sv
// Self-checking bench for the host bus port.
`timescale 1ns/1ps
module tb;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic [1:0] ctrl_status = 2'h0;
   logic stb, rw, cs_n, rs, oe, wr_p;
   logic [7:0] drv, dout, q;
   logic [4:0] idx, wr_i;
   logic [crthp_pkg::NUM_REGS*crthp_pkg::DATA_W-1:0] regs;
   wire logic [7:0] bus = oe ? dout : drv;
   int n_mismatch = 0;
   int n_tests = 0;
   int cyc_n = 0;
   int n_wr = 0;
   logic [4:0] wr_seen = 5'h00;
   always #50 clk_sys = ~clk_sys;
   // The one-cycle pulse is counted at the falling edge, where it has settled.
   always @(negedge clk_sys) begin
      if (wr_p === 1'b1) begin
         n_wr++;
         wr_seen = wr_i;
      end
   end
   crthp_host i_crthp_host (.clk_sys(clk_sys), .xfer_strobe(stb), .read_not_write(rw),
      .chip_select_n(cs_n), .register_select_line(rs), .host_drv(drv), .bus(bus));
   crthp_port i_crthp_port (.clk_sys(clk_sys), .arst_n(arst_n), .xfer_strobe(stb),
      .read_not_write(rw), .chip_select_n(cs_n), .register_select_line(rs),
      .host_data_lines_in(bus), .host_data_lines_out(dout), .host_data_lines_oe(oe),
      .ctrl_status(ctrl_status), .index_ptr(idx), .reg_file_flat(regs),
      .reg_wr_pulse(wr_p), .reg_wr_index(wr_i));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim
   always @(posedge clk_sys) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic t_index;
      i_crthp_host.cyc(1'b0, 1'b0, 1'b0, 8'hff, q);
      chk("index", 8'h1f, {3'h0, idx});
      i_crthp_host.cyc(1'b0, 1'b0, 1'b0, 8'h05, q);
      chk("index", 8'h05, {3'h0, idx});
      chk("pulses", 8'h00, 8'(n_wr));
   endtask : t_index
   task automatic t_nosel;
      i_crthp_host.cyc(1'b1, 1'b0, 1'b0, 8'h1e, q);
      chk("index", 8'h05, {3'h0, idx});
      i_crthp_host.cyc(1'b1, 1'b1, 1'b1, 8'h00, q);
      chk("oe", 8'h00, {7'h0, oe});
      chk("unsel rd", 8'hff, q);
      i_crthp_host.nostb(8'h1b);
      chk("index", 8'h05, {3'h0, idx});
   endtask : t_nosel
   task automatic t_reg;
      i_crthp_host.cyc(1'b0, 1'b0, 1'b0, 8'h1f, q);
      i_crthp_host.cyc(1'b0, 1'b0, 1'b1, 8'ha5, q);
      chk("reg31", 8'ha5, regs[31*8+:8]);
      chk("reg5", 8'h00, regs[5*8+:8]);
      chk("pulses", 8'h01, 8'(n_wr));
      chk("wr index", 8'h1f, {3'h0, wr_seen});
      i_crthp_host.cyc(1'b0, 1'b1, 1'b1, 8'h00, q);
      chk("rd31", 8'ha5, q);
      chk("pulses", 8'h01, 8'(n_wr));
   endtask : t_reg
   task automatic t_reset;
      arst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk("rst index", 8'h00, {3'h0, idx});
      chk("rst reg31", 8'h00, regs[31*8+:8]);
      chk("rst oe", 8'h00, {7'h0, oe});
   endtask : t_reset
   task automatic t_status;
      ctrl_status <= 2'h2;
      i_crthp_host.cyc(1'b0, 1'b1, 1'b0, 8'h00, q);
      chk("status", 8'h02, q);
      ctrl_status <= 2'h1;
      i_crthp_host.cyc(1'b0, 1'b1, 1'b0, 8'h00, q);
      chk("status", 8'h01, q);
      chk("index", 8'h00, {3'h0, idx});
   endtask : t_status
   task automatic t_idle;
      repeat (3000) @(posedge clk_sys);
      i_crthp_host.cyc(1'b0, 1'b0, 1'b0, 8'h0a, q);
      chk("index", 8'h0a, {3'h0, idx});
      chk("oe", 8'h00, {7'h0, oe});
   endtask : t_idle
   initial begin
      repeat (3) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk("index", 8'h00, {3'h0, idx});
      t_index();
      t_nosel();
      t_reg();
      t_reset();
      t_status();
      t_idle();
      end_sim();
   end
endmodule : tb
